/* File: hdl/clo_pkg.sv */
// constants and types for the charge level optimizer
// assumes one 20 MHz clock and a classic wishbone register bus
package clo_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] CLO_IDX_PROF_MSB = 6'h07;
  localparam logic [5:0] CLO_IDX_CMD = 6'h08;
  localparam logic [5:0] CLO_IDX_SET1 = 6'h09;
  localparam logic [5:0] CLO_IDX_SET5 = 6'h12;
  localparam logic [5:0] CLO_IDX_SET6 = 6'h13;
  localparam logic [5:0] CLO_IDX_STAT = 6'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CLO_CMD_EOD = 0;
  localparam int CLO_CMD_ECM = 1;
  localparam int CLO_CMD_ACT = 2;
  localparam int CLO_CMD_RSTPF = 3;
  localparam int CLO_CMD_PROF_LSB = 4;
  localparam int CLO_SET1_VFIX_LSB = 4;
  localparam int CLO_SET5_VCAPMAX = 4;
  localparam int CLO_STAT_STATE_LSB = 4;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [5:0] CLO_PROF_RST = 6'h01;
  localparam logic [1:0] CLO_MARG_RST = 2'h3;
  localparam logic CLO_VCAPMAX_RST = 1'b1;
  localparam logic [3:0] CLO_VFIX_RST = 4'h0;
  localparam logic [1:0] CLO_MODE_RST = 2'h0;

  // ----------------------------------------------------------------
  // level codes and comparison bands
  // ----------------------------------------------------------------
  localparam logic [3:0] CLO_VOPT_MAX_HI = 4'hf;
  localparam logic [3:0] CLO_VOPT_MAX_LO = 4'hb;
  localparam logic [3:0] CLO_VOPT_MIN = 4'h0;
  localparam logic [4:0] CLO_MARG_BASE = 5'h02;
  localparam logic [4:0] CLO_HOLD_BAND = 5'h01;
  localparam logic [4:0] CLO_FAR_GAP = 5'h04;

  typedef enum logic [1:0] {
    CLO_ST_STANDBY,
    CLO_ST_CHARGE,
    CLO_ST_ACTIVE,
    CLO_ST_UPDATE
  } clo_state_t;

endpackage : clo_pkg

/* File: hdl/clo_sync.sv */
// three-stage synchroniser for one pin level
// assumes the pin is asynchronous to i_mclk
`timescale 1ns/10ps
`default_nettype none
module clo_sync (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  output logic o_level
);
  import clo_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level moves only once stages two and three agree
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_level <= 1'b0;
    end else if (s2_q == s3_q) begin
      o_level <= s3_q;
    end
  end
endmodule : clo_sync
`default_nettype wire

/* File: hdl/clo_step.sv */
// next target code from leftover capacitor level and margin
// assumes the capacitor code is on the same clock
`timescale 1ns/10ps
`default_nettype none
module clo_step (
  input wire logic [3:0] i_code,
  input wire logic [4:0] i_vcap,
  input wire logic [1:0] i_marg,
  output logic [3:0] o_next
);
  import clo_pkg::*;

  logic [4:0] thr;
  logic [4:0] gap;

  always_comb begin
    thr = CLO_MARG_BASE + {3'h0, i_marg};
    gap = thr - i_vcap;
    o_next = i_code;
    if (i_vcap > thr + CLO_HOLD_BAND) begin
      // R7 one step down
      if (i_code != CLO_VOPT_MIN) begin
        o_next = i_code - 4'h1;
      end
    end else if (i_vcap < thr) begin
      // R8 below threshold, raise
      // R9 far below, two up
      if (gap >= CLO_FAR_GAP) begin
        o_next = (i_code >= 4'he) ? 4'hf : i_code + 4'h2;
      end else begin
        // R10 moderate, one up
        o_next = (i_code == 4'hf) ? 4'hf : i_code + 4'h1;
      end
    end
    // R11 within band: no change
  end
endmodule : clo_step
`default_nettype wire

/* File: hdl/clo_core.sv */
// charge level optimizer with wishbone register slave
// assumes converter sequencing on i_mclk and an async start pin
//
// Summary of operation
// R1 - one stored target code per profile; selected profile's code is the target
// R2 - profile zero: no learning, charge to the fixed level
// R3 - a new profile starts at the max level chosen by vcapmax
// R4 - on-demand cycle starts from the command bit or start pin
// R5 - charging done leads into the active cycle
// R6 - end of active cycle compares leftover level with margin threshold
// R7 - above threshold: target code down by one; code leaves it unchanged at threshold plus one
// R8 - below threshold: target code up by one or more
// R9 - far below threshold: target code up by two
// R10 - moderately below threshold: target code up by one
// R11 - at threshold: target code unchanged
// R12 - profile init after power-on or on profile reset write
// R13 - margin resets to its highest code
// R14 - selected profile resets to profile one
// R15 - learned profile charges to its stored target code
// R16 - one update per active cycle, sampled on leaving active
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module clo_core (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_start_pin,
  input wire logic i_charge_done,
  input wire logic i_active_end,
  input wire logic [4:0] i_vcap_code,
  output logic o_charge_en,
  output logic o_active_en,
  output logic [3:0] o_target_code
);
  import clo_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  clo_state_t state_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [5:0] prof_q;
  logic [1:0] mode_q;
  logic [3:0] vfix_q;
  logic vcapmax_q;
  logic [1:0] marg_q;
  logic [3:0] vopt_mem [0:63];
  logic [63:0] learned_q;
  logic [5:0] cyc_prof_q;
  logic [4:0] vcap_q;
  logic start_lvl;
  logic start_lvl_q;
  logic start_req;
  logic eod_wr;
  logic rstpf_wr;
  logic wr_en;
  logic rd_en;
  logic [5:0] idx;
  logic [7:0] wbyte;
  logic [3:0] max_code;
  logic [3:0] cyc_code;
  logic [3:0] sel_code;
  logic [3:0] next_code;
  logic [5:0] rst_prof;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // unlearned profiles read the selected max level
  function automatic logic [3:0] code_of(
    input logic seen,
    input logic [3:0] stored,
    input logic [3:0] fallback
  );
    return seen ? stored : fallback;
  endfunction : code_of

  // a zero nibble in the reset write names the current profile
  function automatic logic [5:0] reset_slot(
    input logic [5:0] cur,
    input logic [3:0] nib
  );
    if (nib == 4'h0) begin
      return cur;
    end
    return {cur[5:4], nib};
  endfunction : reset_slot

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  assign idx = i_wb_adr[7:2];
  assign wbyte = i_wb_dat[7:0];
  assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && !ack_q && i_wb_sel[0];
  assign rd_en = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q;
  assign eod_wr = wr_en && (idx == CLO_IDX_CMD) && wbyte[CLO_CMD_EOD];
  assign rstpf_wr = wr_en && (idx == CLO_IDX_CMD) && wbyte[CLO_CMD_RSTPF];
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // one ack per access, dropped the cycle after
  // no wait states: ack follows the edge that takes the request
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // R14 profile one after power-on
      prof_q <= CLO_PROF_RST;
      mode_q <= CLO_MODE_RST;
      vfix_q <= CLO_VFIX_RST;
      vcapmax_q <= CLO_VCAPMAX_RST;
      // R13 highest margin code
      marg_q <= CLO_MARG_RST;
    end else if (wr_en) begin
      case (idx)
        CLO_IDX_PROF_MSB: prof_q[5:4] <= wbyte[1:0];
        CLO_IDX_CMD: begin
          prof_q[3:0] <= wbyte[CLO_CMD_PROF_LSB +: 4];
          mode_q <= wbyte[CLO_CMD_ACT:CLO_CMD_ECM];
        end
        CLO_IDX_SET1: vfix_q <= wbyte[CLO_SET1_VFIX_LSB +: 4];
        CLO_IDX_SET5: vcapmax_q <= wbyte[CLO_SET5_VCAPMAX];
        CLO_IDX_SET6: marg_q <= wbyte[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data, unmapped reads return zero
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdat_q <= 32'h0;
    end else if (rd_en) begin
      rdat_q <= 32'h0;
      case (idx)
        CLO_IDX_PROF_MSB: rdat_q[1:0] <= prof_q[5:4];
        CLO_IDX_CMD: begin
          rdat_q[CLO_CMD_PROF_LSB +: 4] <= prof_q[3:0];
          rdat_q[CLO_CMD_ACT:CLO_CMD_ECM] <= mode_q;
        end
        CLO_IDX_SET1: rdat_q[CLO_SET1_VFIX_LSB +: 4] <= vfix_q;
        CLO_IDX_SET5: rdat_q[CLO_SET5_VCAPMAX] <= vcapmax_q;
        CLO_IDX_SET6: rdat_q[1:0] <= marg_q;
        CLO_IDX_STAT: begin
          rdat_q[CLO_STAT_STATE_LSB +: 2] <= state_q;
          rdat_q[3:0] <= sel_code;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // start pin
  // ----------------------------------------------------------------
  clo_sync u_start_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_start_pin),
    .o_level(start_lvl)
  );

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_lvl_q <= 1'b0;
    end else begin
      start_lvl_q <= start_lvl;
    end
  end

  // R4 command bit or pin edge
  assign start_req = eod_wr || (start_lvl && !start_lvl_q);

  // ----------------------------------------------------------------
  // profile store
  // ----------------------------------------------------------------
  // R3 fresh profile begins at the selected max level
  assign max_code = vcapmax_q ? CLO_VOPT_MAX_HI : CLO_VOPT_MAX_LO;
  // R1 stored code of the selected profile
  assign sel_code = code_of(learned_q[prof_q], vopt_mem[prof_q], max_code);
  assign cyc_code = code_of(learned_q[cyc_prof_q], vopt_mem[cyc_prof_q],
    max_code);
  assign rst_prof = reset_slot(prof_q, wbyte[CLO_CMD_PROF_LSB +: 4]);

  // R12 power-on and profile reset both forget the profile
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      learned_q <= 64'h0;
    end else begin
      // a reset of another profile must not be lost to an update
      if (rstpf_wr) begin
        learned_q[rst_prof] <= 1'b0;
      end
      // later assignment: an update of the same profile wins
      if (state_q == CLO_ST_UPDATE && cyc_prof_q != 6'h0) begin
        learned_q[cyc_prof_q] <= 1'b1;
      end
    end
  end

  // no reset: an entry is read only once its profile is learned
  // R16 written once, in the update state only
  always_ff @(posedge i_mclk) begin
    if (state_q == CLO_ST_UPDATE && cyc_prof_q != 6'h0) begin
      vopt_mem[cyc_prof_q] <= next_code;
    end
  end

  clo_step u_step (
    .i_code(cyc_code),
    .i_vcap(vcap_q),
    .i_marg(marg_q),
    .o_next(next_code)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= CLO_ST_STANDBY;
    end else begin
      case (state_q)
        CLO_ST_STANDBY: begin
          // R4 begin charging
          if (start_req) begin
            state_q <= CLO_ST_CHARGE;
          end
        end
        CLO_ST_CHARGE: begin
          // R5 charged, supply the load
          if (i_charge_done) begin
            state_q <= CLO_ST_ACTIVE;
          end
        end
        CLO_ST_ACTIVE: begin
          // R6 leave once the load cycle ends
          if (i_active_end) begin
            state_q <= CLO_ST_UPDATE;
          end
        end
        CLO_ST_UPDATE: begin
          // R16 one cycle for the single store write
          state_q <= CLO_ST_STANDBY;
        end
        default: state_q <= CLO_ST_STANDBY;
      endcase
    end
  end

  // profile held for the whole cycle so a mid-cycle write is safe
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cyc_prof_q <= CLO_PROF_RST;
    end else if (state_q == CLO_ST_STANDBY && start_req) begin
      // R1 a start write may also select the profile
      cyc_prof_q <= eod_wr ? {prof_q[5:4], wbyte[CLO_CMD_PROF_LSB +: 4]} :
        prof_q;
    end
  end

  // R6 leftover level sampled as active ends
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vcap_q <= 5'h0;
    end else if (state_q == CLO_ST_ACTIVE && i_active_end) begin
      vcap_q <= i_vcap_code;
    end
  end

  // ----------------------------------------------------------------
  // converter controls
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_target_code <= CLO_VFIX_RST;
    end else if (cyc_prof_q == 6'h0) begin
      // R2 fixed level, nothing learned
      o_target_code <= vfix_q;
    end else begin
      // R15 learned target for the charge
      o_target_code <= cyc_code;
    end
  end

  assign o_charge_en = (state_q == CLO_ST_CHARGE);
  assign o_active_en = (state_q == CLO_ST_ACTIVE);

endmodule : clo_core
`default_nettype wire

/* File: testbench/clo_conv_model.sv */
// converter sequencing stand-in: ends the charge and active phases
// assumes the optimizer clock; the bench sets delay and leftover level
`timescale 1ns/10ps
`default_nettype none
module clo_conv_model (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_chg,
  input wire logic i_act,
  input wire logic [3:0] i_dly,
  input wire logic [4:0] i_vcap,
  output logic o_done,
  output logic o_end,
  output logic [4:0] o_vcap
);
  logic [3:0] cnt_q;
  logic busy;

  // ----------------------------------------------------------------
  // phase timing
  // ----------------------------------------------------------------
  // level only meaningful while active
  assign o_vcap = i_act ? i_vcap : ~i_vcap;
  assign busy = (i_chg && !o_done) || (i_act && !o_end);

  // phase ends after the set delay
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= 4'h0;
      o_done <= 1'b0;
      o_end <= 1'b0;
    end else begin
      o_done <= i_chg && !o_done && cnt_q == i_dly;
      o_end <= i_act && !o_end && cnt_q == i_dly;
      cnt_q <= (busy && cnt_q != i_dly) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule : clo_conv_model
`default_nettype wire

/* File: testbench/clo_core_chk.sv */
// concurrent checks on the optimizer's bus and sequencing ports
// assumes one clock domain; bound into clo_core below
`timescale 1ns/10ps
`default_nettype none
module clo_core_chk (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_charge_done,
  input wire logic i_active_end,
  input wire logic o_charge_en,
  input wire logic o_active_en,
  input wire logic [3:0] o_target_code
);
  import clo_pkg::*;
  logic take;
  logic eod_wr;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign eod_wr = take & i_wb_we & i_wb_sel[0] & i_wb_dat[CLO_CMD_EOD]
    & (i_wb_adr[7:2] == CLO_IDX_CMD);

  ack_answer_a: assert property (take |=> o_wb_ack)
    else $error("no ack after request");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  start_take_a: assert property (eod_wr && !o_charge_en && !o_active_en
    && !$past(o_active_en) |=> o_charge_en)
    else $error("start write did not begin charge");
  phase_excl_a: assert property (!(o_charge_en && o_active_en))
    else $error("charge and active together");
  chg_act_a: assert property (o_charge_en && i_charge_done |=> o_active_en)
    else $error("no active after charge");
  chg_hold_a: assert property (o_charge_en && !i_charge_done |=> o_charge_en)
    else $error("charge ended early");
  act_hold_a: assert property (o_active_en && !i_active_end |=> o_active_en)
    else $error("active ended early");
  act_end_a: assert property (o_active_en && i_active_end
    |=> (!o_active_en && !o_charge_en) [*2])
    else $error("no update gap after active");
  tgt_stable_a: assert property (o_active_en && $past(o_active_en)
    |-> $stable(o_target_code))
    else $error("target moved while active");
endmodule : clo_core_chk

bind clo_core clo_core_chk u_chk (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_charge_done(i_charge_done),
  .i_active_end(i_active_end), .o_charge_en(o_charge_en),
  .o_active_en(o_active_en), .o_target_code(o_target_code));
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench: wishbone host, start pin, converter stand-in
// assumes 20 MHz clock; expected codes come from an integer model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import clo_pkg::*;
  logic mclk, rst, cyc, stb, we, pin, ack, cen, aen, done, aend;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, tmp;
  logic [3:0] dly, tgt;
  logic [4:0] vin, vcap;
  int n_errors, checked, seed, cur, marg, vmax, vfix, i;
  int code [64];
  int vs [12] = '{8, 7, 6, 5, 1, 9, 3, 8, 8, 8, 0, 2};

  clo_core uut (.i_mclk(mclk), .i_sys_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_start_pin(pin),
    .i_charge_done(done), .i_active_end(aend), .i_vcap_code(vcap),
    .o_charge_en(cen), .o_active_en(aen), .o_target_code(tgt));
  clo_conv_model u_conv (.i_mclk(mclk), .i_sys_rst(rst), .i_chg(cen),
    .i_act(aen), .i_dly(dly), .i_vcap(vin), .o_done(done), .o_end(aend),
    .o_vcap(vcap));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // request held until the edge that samples ack high
  task automatic wb(input logic w, input logic [5:0] x, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {x, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    tmp = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : wb

  task automatic rdc(input logic [5:0] x, input logic [31:0] e);
    wb(1'b0, x, 8'h00);
    chk(tmp, e);
  endtask : rdc

  function automatic int nxt(int c, int v, int m);
    int t;
    t = 2 + m;
    if (v > t + 1) return (c > 0) ? c - 1 : 0;
    if (v >= t) return c;
    if (t - v >= 4) return (c + 2 > 15) ? 15 : c + 2;
    return (c + 1 > 15) ? 15 : c + 1;
  endfunction : nxt

  task automatic run(input bit use_pin, input int v, input bit extra);
    int n, e;
    n = 0;
    e = (cur == 0) ? vfix : ((code[cur] < 0) ? vmax : code[cur]);
    vin <= v[4:0];
    dly <= extra ? 4'h9 : 4'h3 + 4'($random(seed) & 3);
    if (use_pin) begin
      pin <= 1'b1;
      // held past the filter: stages two and three must agree
      repeat (3) @(posedge mclk);
      pin <= 1'b0;
    end else wb(1'b1, CLO_IDX_CMD, {cur[3:0], 4'h1});
    while (cen !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, cen}, 32'h1);
    repeat (2) @(posedge mclk);
    chk({28'h0, tgt}, e);
    while (aen !== 1'b1 && n < 80) begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, aen}, 32'h1);
    if (extra) wb(1'b1, CLO_IDX_CMD, {cur[3:0], 4'h1});
    while (aen !== 1'b0 && n < 120) begin
      @(posedge mclk);
      n++;
    end
    repeat (3) @(posedge mclk);
    chk({30'h0, cen, aen}, 32'h0);
    if (cur != 0) begin
      code[cur] = nxt(e, v, marg);
      rdc(CLO_IDX_STAT, code[cur]);
    end
  endtask : run

  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    #400000;
    n_errors++;
    wrap_up();
  end

  initial begin
    {cyc, stb, we, pin, adr, wdat, vin, dly} = '0;
    rst = 1'b1;
    seed = 23;
    foreach (code[k]) code[k] = -1;
    {cur, marg, vmax, vfix} = {32'd1, 32'd3, 32'd15, 32'd0};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdc(CLO_IDX_SET6, 32'h3);
    rdc(CLO_IDX_CMD, 32'h10);
    rdc(CLO_IDX_SET5, 32'h10);
    rdc(6'h3f, 32'h0);
    rdc(CLO_IDX_PROF_MSB, 32'h0);
    wb(1'b1, CLO_IDX_CMD, 8'h16);
    rdc(CLO_IDX_CMD, 32'h16);
    for (i = 0; i < 12; i++) run(i[0], vs[i], 1'b0);
    repeat (6) begin
      marg = $random(seed) & 3;
      wb(1'b1, CLO_IDX_SET6, marg[7:0]);
      run(1'b0, $random(seed) & 31, 1'b0);
    end
    run(1'b1, 6, 1'b1);
    wb(1'b1, CLO_IDX_CMD, 8'h18);
    code[1] = -1;
    rdc(CLO_IDX_STAT, 32'hf);
    wb(1'b1, CLO_IDX_SET5, 8'h00);
    vmax = 11;
    cur = 2;
    wb(1'b1, CLO_IDX_CMD, 8'h20);
    run(1'b1, 0, 1'b0);
    wb(1'b1, CLO_IDX_SET1, 8'h90);
    vfix = 9;
    rdc(CLO_IDX_SET1, 32'h90);
    cur = 0;
    wb(1'b1, CLO_IDX_CMD, 8'h00);
    run(1'b0, 0, 1'b0);
    run(1'b1, 9, 1'b0);
    rdc(CLO_IDX_STAT, 32'hb);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
